// *** design/sad_pkg.sv ***
package sad_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int         ADDR_W     = 10;
  localparam logic [3:0] BIT_EVAL   = 4'h8;
  localparam logic [3:0] BIT_ACK    = 4'h9;

  // ----------------------------------------------------------------
  // Address patterns
  // ----------------------------------------------------------------
  localparam logic [7:0] GC_BYTE    = 8'h00;
  localparam logic [4:0] TEN_PREFIX = 5'h1E;
  localparam logic [3:0] RSV_LOW    = 4'h0;
  localparam logic [3:0] RSV_HIGH   = 4'hF;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RSR_RESET  = 8'h00;
  localparam logic [3:0] CNT_RESET  = 4'h0;

  // ----------------------------------------------------------------
  // Slave address state, Gray along idle-addr1-addr2-data
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_ADDR1  = 3'h1,
    ST_ADDR2  = 3'h3,
    ST_DATA   = 3'h2,
    ST_IGNORE = 3'h6
  } sad_state_type;

endpackage

// *** design/sad_lines_if.sv ***
interface sad_lines_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  modport src (
    output scl,
    output sda,
    output scl_rise,
    output scl_fall,
    output start_seen,
    output stop_seen
  );

  modport dst (
    input scl,
    input sda,
    input scl_rise,
    input scl_fall,
    input start_seen,
    input stop_seen
  );
endinterface

// *** design/sad_line_sync.sv ***
module sad_line_sync
  import sad_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic scl_pin,
  input  wire logic sda_pin,
  sad_lines_if.src  lines
);

  // ----------------------------------------------------------------
  // Two-stage synchronisers and previous samples
  // ----------------------------------------------------------------
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic       scl_last_reg;
  logic       sda_last_reg;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_last_reg <= 1'h1;
      sda_last_reg <= 1'h1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_pin};
      sda_sync_reg <= {sda_sync_reg[0], sda_pin};
      scl_last_reg <= scl_sync_reg[1];
      sda_last_reg <= sda_sync_reg[1];
    end
  end

  // ----------------------------------------------------------------
  // Edge and bus condition decode
  // ----------------------------------------------------------------
  wire scl_high_both = scl_sync_reg[1] & scl_last_reg;

  assign lines.scl        = scl_sync_reg[1];
  assign lines.sda        = sda_sync_reg[1];
  assign lines.scl_rise   = scl_sync_reg[1] & ~scl_last_reg;
  assign lines.scl_fall   = ~scl_sync_reg[1] & scl_last_reg;
  assign lines.start_seen = scl_high_both & sda_last_reg & ~sda_sync_reg[1];
  assign lines.stop_seen  = scl_high_both & ~sda_last_reg & sda_sync_reg[1];

endmodule

// *** design/sad_addr_detect.sv ***
module sad_addr_detect
  import sad_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire logic              module_enable,
  input  wire logic              broadcast_enable,
  input  wire logic              accept_all_enable,
  input  wire logic              ten_bit_addr_mode,
  input  wire logic [ADDR_W-1:0] own_address,
  input  wire logic [ADDR_W-1:0] address_mask,
  input  wire logic              buffer_read,
  input  wire logic              interrupt_clear,
  input  wire logic              bus_clock_line_in,
  input  wire logic              bus_data_line_in,
  output logic                   bus_data_line_out,
  output logic                   bus_data_line_oe_n,
  output logic [7:0]             receive_buffer,
  output logic                   buffer_full_flag,
  output logic                   broadcast_seen_flag,
  output logic                   data_address_flag,
  output logic                   read_write_flag,
  output logic                   ten_bit_done_flag,
  output logic                   slave_interrupt_flag
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic masked_eq(input logic [7:0] a, input logic [7:0] b,
                                     input logic [7:0] m);
    return &(~(a ^ b) | m);
  endfunction

  function automatic logic reserved7(input logic [6:0] a);
    return (a[6:3] == RSV_LOW) || (a[6:3] == RSV_HIGH);
  endfunction

  // ----------------------------------------------------------------
  // Line synchroniser
  // ----------------------------------------------------------------
  sad_lines_if lines ();

  sad_line_sync u_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .scl_pin (bus_clock_line_in),
    .sda_pin (bus_data_line_in),
    .lines   (lines)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  sad_state_type state_reg;
  sad_state_type state_next;
  logic [3:0]    bit_cnt_reg;
  logic [7:0]    rsr_reg;
  logic [7:0]    rcv_reg;
  logic          rbf_reg;
  logic          gc_seen_reg;
  logic          dna_reg;
  logic          rnw_reg;
  logic          add10_reg;
  logic          intr_reg;
  logic          ack_drive_reg;
  logic          ten_matched_reg;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire [ADDR_W-1:0] mask_eff = accept_all_enable ? '0 : address_mask;
  wire in_addr = (state_reg == ST_ADDR1) || (state_reg == ST_ADDR2);
  wire eval = module_enable && lines.scl_fall && (bit_cnt_reg == BIT_EVAL) && in_addr;
  wire ack_end = lines.scl_fall && (bit_cnt_reg == BIT_ACK);
  wire gc_hit = broadcast_enable && (rsr_reg == GC_BYTE);
  wire rsvd_hit = reserved7(rsr_reg[7:1]);
  wire own7_hit = !ten_bit_addr_mode && !rsvd_hit
                  && masked_eq({1'b0, rsr_reg[7:1]}, {1'b0, own_address[6:0]},
                               {1'b0, mask_eff[6:0]});
  wire hi_any = ten_bit_addr_mode && (rsr_reg[7:3] == TEN_PREFIX)
                && masked_eq({6'h00, rsr_reg[2:1]}, {6'h00, own_address[9:8]},
                             {6'h00, mask_eff[9:8]});
  wire hi_hit = hi_any && !rsr_reg[0];
  wire resume_hit = hi_any && ten_matched_reg;
  wire lo_hit = masked_eq(rsr_reg, own_address[7:0], mask_eff[7:0]);
  wire first_done = accept_all_enable || gc_hit || own7_hit || resume_hit;
  wire first_ok = first_done || hi_hit;
  wire addr_ok = (state_reg == ST_ADDR1) ? first_ok : (lo_hit || accept_all_enable);
  wire gc_take = eval && (state_reg == ST_ADDR1) && gc_hit;
  wire shift_en = lines.scl_rise && in_addr && (bit_cnt_reg < BIT_EVAL);

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_ADDR1: begin
        if (eval) begin
          state_next = first_done ? ST_DATA : (hi_hit ? ST_ADDR2 : ST_IGNORE);
        end
      end
      ST_ADDR2: begin
        if (eval) begin
          state_next = addr_ok ? ST_DATA : ST_IGNORE;
        end
      end
      ST_IDLE, ST_DATA, ST_IGNORE: state_next = state_reg;
      default: state_next = ST_IDLE;
    endcase
    if (lines.start_seen) begin
      state_next = ST_ADDR1;
    end else if (lines.stop_seen) begin
      state_next = ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= module_enable ? state_next : ST_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Bit counter and shift register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_reg <= CNT_RESET;
    end else if (!module_enable || lines.start_seen || ack_end) begin
      bit_cnt_reg <= CNT_RESET;
    end else if (lines.scl_rise && (bit_cnt_reg != BIT_ACK)) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rsr_reg <= RSR_RESET;
    end else if (shift_en) begin
      rsr_reg <= {rsr_reg[6:0], lines.sda};
    end
  end

  // ----------------------------------------------------------------
  // Acknowledge drive
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_drive_reg <= 1'b0;
    end else if (!module_enable || lines.start_seen || lines.stop_seen || ack_end) begin
      ack_drive_reg <= 1'b0;
    end else if (eval && addr_ok) begin
      ack_drive_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Status bits
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      gc_seen_reg <= 1'b0;
      dna_reg     <= 1'b0;
      rnw_reg     <= 1'b0;
      add10_reg   <= 1'b0;
    end else if (!module_enable) begin
      gc_seen_reg <= 1'b0;
      dna_reg     <= 1'b0;
      rnw_reg     <= 1'b0;
      add10_reg   <= 1'b0;
    end else if (eval && addr_ok) begin
      gc_seen_reg <= gc_take;
      dna_reg     <= 1'b0;
      rnw_reg     <= (state_reg == ST_ADDR1) && !gc_take && rsr_reg[0];
      add10_reg   <= (state_reg == ST_ADDR2) || resume_hit;
    end else if (lines.start_seen) begin
      gc_seen_reg <= 1'b0;
      add10_reg   <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ten_matched_reg <= 1'b0;
    end else if (!module_enable || lines.stop_seen) begin
      ten_matched_reg <= 1'b0;
    end else if (eval && (state_reg == ST_ADDR2) && lo_hit) begin
      ten_matched_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer and interrupt, set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rcv_reg <= RSR_RESET;
      rbf_reg <= 1'b0;
    end else if (gc_take) begin
      rcv_reg <= rsr_reg;
      rbf_reg <= 1'b1;
    end else if (buffer_read || !module_enable) begin
      rbf_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      intr_reg <= 1'b0;
    end else if (ack_end && ack_drive_reg) begin
      intr_reg <= 1'b1;
    end else if (interrupt_clear || !module_enable) begin
      intr_reg <= 1'b0;
    end
  end

  assign bus_data_line_out    = 1'b0;
  assign bus_data_line_oe_n   = ~ack_drive_reg;
  assign receive_buffer       = rcv_reg;
  assign buffer_full_flag     = rbf_reg;
  assign broadcast_seen_flag  = gc_seen_reg;
  assign data_address_flag    = dna_reg;
  assign read_write_flag      = rnw_reg;
  assign ten_bit_done_flag    = add10_reg;
  assign slave_interrupt_flag = intr_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_GC_NEEDS_ENABLE: assert property (
    eval && (rsr_reg == GC_BYTE) && !broadcast_enable && !accept_all_enable
    && (state_reg == ST_ADDR1) |=> !broadcast_seen_flag && bus_data_line_oe_n)
    else $error("general call taken while disabled");

  AST_GC_STATUS: assert property (
    gc_take |=> broadcast_seen_flag && !data_address_flag && !read_write_flag
                && !bus_data_line_oe_n && (state_reg == ST_DATA))
    else $error("general call status wrong");

  AST_GC_INTR: assert property (
    ack_end && broadcast_seen_flag && !bus_data_line_oe_n
    |=> slave_interrupt_flag && bus_data_line_oe_n)
    else $error("no interrupt at ninth falling edge");

  AST_GC_BUFFER: assert property (
    gc_take |=> buffer_full_flag && (receive_buffer == $past(rsr_reg)))
    else $error("general call not loaded into buffer");

  AST_GC_TEN_BIT: assert property (
    eval && (state_reg == ST_ADDR1) && ten_bit_addr_mode && broadcast_enable
    && (rsr_reg == GC_BYTE) |=> broadcast_seen_flag)
    else $error("general call missed in ten-bit mode");

  AST_ACCEPT_ALL: assert property (
    eval && accept_all_enable |=> !bus_data_line_oe_n ##0 (state_reg == ST_DATA))
    else $error("accept-all address not acknowledged");

  AST_MISMATCH7: assert property (
    eval && (state_reg == ST_ADDR1) && !ten_bit_addr_mode && !accept_all_enable
    && !gc_hit && !own7_hit && !lines.start_seen
    |=> (state_reg == ST_IGNORE) && bus_data_line_oe_n)
    else $error("seven-bit mismatch not ignored");

  AST_MISMATCH_HI: assert property (
    eval && (state_reg == ST_ADDR1) && ten_bit_addr_mode && !accept_all_enable
    && !gc_hit && !hi_any && !lines.start_seen |=> state_reg == ST_IGNORE)
    else $error("ten-bit first byte mismatch not ignored");

  AST_MISMATCH_LO: assert property (
    eval && (state_reg == ST_ADDR2) && !lo_hit && !accept_all_enable
    && !lines.start_seen |=> state_reg == ST_IGNORE)
    else $error("ten-bit second byte mismatch not ignored");

  AST_RESERVED: assert property (
    eval && (state_reg == ST_ADDR1) && rsvd_hit && (rsr_reg != GC_BYTE)
    && !accept_all_enable && !resume_hit && !hi_hit |=> bus_data_line_oe_n)
    else $error("reserved address acknowledged");

endmodule

// *** test/sad_i2c_master.sv ***
module sad_i2c_master (
  input  wire logic sys_clk,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda,
  output logic      in_ack
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Bus master, 80 ns bus clock, idle lines high
  // ----------------------------------------------------------------
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    in_ack = 1'b0;
  end

  // Quarter bus clock period
  task automatic q();
    repeat (4) @(negedge sys_clk);
  endtask

  task automatic start();
    sda = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda = 1'b0;
    q();
    scl = 1'b0;
    q();
  endtask

  task automatic stop();
    sda = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda = 1'b1;
    q();
  endtask

  // Eight bits MSB first, then data line released for the ninth clock
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= -1; i--) begin
      sda = (i < 0) ? 1'b1 : b[i];
      q();
      scl = 1'b1;
      in_ack = (i < 0);
      q();
      q();
      if (i < 0) ack = ~sda_wire;
      scl = 1'b0;
      in_ack = 1'b0;
      q();
    end
  endtask
endmodule

// *** test/sad_addr_detect_tb.sv ***
module sad_addr_detect_tb
  import sad_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              sys_clk;
  logic              reset_n;
  logic              module_enable;
  logic              broadcast_enable;
  logic              accept_all_enable;
  logic              ten_bit_addr_mode;
  logic [ADDR_W-1:0] own_address;
  logic [ADDR_W-1:0] address_mask;
  logic              buffer_read;
  logic              interrupt_clear;
  logic              bus_clock_line_in;
  logic              master_sda;
  logic              in_ack;
  wire logic         bus_data_line_in;
  logic              bus_data_line_out;
  logic              bus_data_line_oe_n;
  logic [7:0]        receive_buffer;
  logic              buffer_full_flag;
  logic              broadcast_seen_flag;
  logic              data_address_flag;
  logic              read_write_flag;
  logic              ten_bit_done_flag;
  logic              slave_interrupt_flag;
  logic [6:0]        a;
  logic [7:0]        hi;
  logic [7:0]        lo;
  logic              rw;
  logic              e;
  int                mismatches;
  int                comparisons;

  // Open-drain data line with pull-up
  assign bus_data_line_in = master_sda & (bus_data_line_oe_n | bus_data_line_out);

  sad_addr_detect i_sad_addr_detect (.sys_clk, .reset_n, .module_enable, .broadcast_enable,
    .accept_all_enable, .ten_bit_addr_mode, .own_address, .address_mask, .buffer_read,
    .interrupt_clear, .bus_clock_line_in, .bus_data_line_in, .bus_data_line_out,
    .bus_data_line_oe_n, .receive_buffer, .buffer_full_flag, .broadcast_seen_flag,
    .data_address_flag, .read_write_flag, .ten_bit_done_flag, .slave_interrupt_flag);

  sad_i2c_master i_sad_i2c_master (.sys_clk(sys_clk), .sda_wire(bus_data_line_in),
    .scl(bus_clock_line_in), .sda(master_sda), .in_ack(in_ack));

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Expected acknowledge of a seven-bit address byte
  function automatic logic exp7(input logic [6:0] ad, input logic d);
    if (accept_all_enable) return 1'b1;
    if (ad == 7'h00 && !d) return broadcast_enable;
    if (ad[6:3] == 4'h0 || ad[6:3] == 4'hF) return 1'b0;
    return ((ad ^ own_address[6:0]) & ~address_mask[6:0]) == 7'h00;
  endfunction

  // One address byte with acknowledge and interrupt compare
  task automatic xfer(input logic [7:0] b, input logic ex, input string m);
    logic ack;
    interrupt_clear = 1'b1;
    @(negedge sys_clk);
    interrupt_clear = 1'b0;
    i_sad_i2c_master.put(b, ack);
    repeat (2) @(negedge sys_clk);
    check(ack, ex, m);
    check(slave_interrupt_flag, ex, m);
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial begin
    #480000;
    mismatches++;
    results();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {reset_n, module_enable, broadcast_enable, accept_all_enable} = 4'h0;
    {ten_bit_addr_mode, buffer_read, interrupt_clear} = 3'h0;
    own_address = 10'h0A5;
    address_mask = 10'h000;
    void'($urandom(62));
    repeat (6) @(negedge sys_clk);
    reset_n = 1'b1;
    module_enable = 1'b1;
    repeat (4) @(negedge sys_clk);
    for (int k = 0; k < 4; k++) begin
      {ten_bit_addr_mode, broadcast_enable} = 2'(k);
      i_sad_i2c_master.start();
      fork
        xfer(GC_BYTE, broadcast_enable, "gc ack");
        begin
          @(posedge in_ack);
          check(buffer_full_flag, broadcast_enable, "gc full");
          check(slave_interrupt_flag, 1'b0, "gc early irq");
          check({bus_data_line_out, bus_data_line_oe_n}, {1'b0, !broadcast_enable}, "gc drive");
        end
      join
      check(broadcast_seen_flag, broadcast_enable, "gc seen");
      check(read_write_flag, 1'b0, "gc dir");
      check(data_address_flag, 1'b0, "gc da");
      check(receive_buffer, GC_BYTE, "gc buffer");
      i_sad_i2c_master.stop();
      buffer_read = 1'b1;
      @(negedge sys_clk);
      buffer_read = 1'b0;
      @(negedge sys_clk);
      check(buffer_full_flag, 1'b0, "buffer read");
    end
    module_enable = 1'b0;
    repeat (2) @(negedge sys_clk);
    check(broadcast_seen_flag, 1'b0, "disable");
    module_enable = 1'b1;
    $display("test general call done");
    for (int i = 0; i < 256; i++) begin
      accept_all_enable = i >= 224;
      ten_bit_addr_mode = accept_all_enable & 1'($urandom);
      broadcast_enable = 1'($urandom);
      own_address = 10'($urandom);
      address_mask = (i < 128) ? 10'h3FF : 10'($urandom & $urandom);
      if (i < 128) a = 7'(i);
      else if (i % 2 == 1) a = own_address[6:0] ^ (7'($urandom) & address_mask[6:0]);
      else a = 7'($urandom);
      rw = 1'($urandom);
      e = exp7(a, rw);
      i_sad_i2c_master.start();
      xfer({a, rw}, e, "addr");
      if (e) check(read_write_flag, rw, "dir");
      else xfer({own_address[6:0], 1'b0}, 1'b0, "ignored");
      i_sad_i2c_master.stop();
    end
    $display("test seven bit and accept all done");
    accept_all_enable = 1'b0;
    ten_bit_addr_mode = 1'b1;
    for (int j = 0; j < 12; j++) begin
      broadcast_enable = 1'($urandom);
      own_address = 10'($urandom);
      address_mask = 10'($urandom & $urandom) & 10'h2FE;
      hi = {5'h1E, own_address[9:8] ^ address_mask[9:8], 1'b0};
      lo = own_address[7:0] ^ address_mask[7:0];
      if (j % 3 == 1) hi[1] = ~hi[1];
      if (j % 3 == 2) lo[0] = ~lo[0];
      i_sad_i2c_master.start();
      xfer(hi, j % 3 != 1, "ten hi");
      xfer(lo, j % 3 == 0, "ten lo");
      check(ten_bit_done_flag, j % 3 == 0, "ten done");
      if (j % 3 == 0) begin
        i_sad_i2c_master.start();
        xfer({hi[7:1], 1'b1}, 1'b1, "ten resume");
        check({read_write_flag, ten_bit_done_flag}, 2'h3, "ten resume dir");
      end
      i_sad_i2c_master.stop();
    end
    $display("test ten bit done");
    results();
  end
endmodule
